//--- dv/station_address_mode_regs_properties.sv
// Checker of the address and mode bank port behaviour.
`timescale 1ns/10ps
`default_nettype none
module station_address_mode_regs_properties
    import addr_mode_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire host_req_s hostReq,
    input wire logic [REG_W-1:0] rdData,
    input wire init_load_s initLoad,
    input wire logic activityBusy,
    input wire logic destIsBroadcast,
    input wire logic destIsOwn,
    input wire logic destHashHit,
    input wire logic extAddrAccept,
    input wire logic frameCheck,
    input wire logic addrShiftStart,
    input wire logic frameAccept,
    input wire logic addrBit,
    input wire logic addrBitValid,
    input wire logic [STATION_BITS-1:0] stationAddress,
    input wire logic [4:0] modeCtl,
    input wire logic linkMonitorOn,
    input wire logic polarityFixOn,
    input wire logic stopped,
    input wire logic suspended
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    wire winOpen = stopped | suspended;
    wire modeWr = hostReq.wr && hostReq.addr == IDX_MODE && !initLoad.wr;
    reset_mode_a: assert property ($rose(arst_n) |-> modeCtl == 5'h0 && !suspended)
        else $error("mode bits not clear after reset");
    read_gate_a: assert property (hostReq.rd && hostReq.addr[3] && !winOpen |=> rdData == READ_ZERO)
        else $error("gated read returned data");
    blocked_write_a: assert property (modeWr && !winOpen ##1 !hostReq.wr && !initLoad.wr |=> $stable(modeCtl))
        else $error("blocked mode write took effect");
    mode_write_a: assert property (modeWr && winOpen |-> ##2 modeCtl == $past(hostReq.data[15:11], 2))
        else $error("mode write not applied");
    frame_accept_a: assert property (frameCheck |=> frameAccept == (modeCtl[4] |
        $past(destIsBroadcast) & !modeCtl[3] | $past(destIsOwn) & !modeCtl[2] |
        $past(destHashHit) | $past(extAddrAccept))) else $error("frame accept wrong");
    shift_first_a: assert property (addrShiftStart |=> addrBitValid && addrBit == stationAddress[0])
        else $error("first address bit wrong");
    shift_last_a: assert property (addrShiftStart |-> ##48 addrBitValid && addrBit == stationAddress[47]
        ##1 !addrBitValid) else $error("last address bit wrong");
    link_pol_a: assert property ((modeCtl[1] && $past(modeCtl[1]) |-> !linkMonitorOn)
        and (modeCtl[0] && $past(modeCtl[0]) |-> !polarityFixOn)) else $error("disable bit ignored");
    suspend_idle_a: assert property ($rose(suspended) |-> !$past(activityBusy))
        else $error("suspend entered while busy");
    stop_wake_a: assert property (hostReq.wr && hostReq.addr == IDX_CONTROL && hostReq.data[CTL_STOP]
        |=> ##1 stopped && !suspended) else $error("stop did not leave suspend");
    accept_c: cover property (frameAccept);
    shift_c: cover property ($fell(addrBitValid));
    suspend_c: cover property ($rose(suspended));
endmodule : station_address_mode_regs_properties
bind station_address_mode_regs station_address_mode_regs_properties checker_i (.sys_clk, .arst_n,
    .hostReq, .rdData, .initLoad, .activityBusy, .destIsBroadcast, .destIsOwn, .destHashHit,
    .extAddrAccept, .frameCheck, .addrShiftStart, .frameAccept, .addrBit, .addrBitValid,
    .stationAddress, .modeCtl, .linkMonitorOn, .polarityFixOn, .stopped, .suspended);
`default_nettype wire

//--- dv/station_address_mode_regs_test.sv
// Self-checking bench of the address and mode register bank.
`timescale 1ns/10ps
`default_nettype none
module station_address_mode_regs_test
    import addr_mode_pkg::*;
;
    localparam logic [47:0] STA = 48'h7777_6666_5555;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    host_req_s hostReq = '0;
    init_load_s initLoad = '0;
    logic activityBusy = 1'b0;
    logic twistedPairSel = 1'b1;
    logic destIsBroadcast = 1'b0, destIsOwn = 1'b0, destHashHit = 1'b0, extAddrAccept = 1'b0;
    logic frameCheck = 1'b0;
    logic addrShiftStart = 1'b0;
    logic [15:0] rdData;
    logic frameAccept, addrBit, addrBitValid, linkMonitorOn, polarityFixOn, stopped, suspended;
    logic [63:0] multicastHashFilter;
    logic [47:0] stationAddress;
    logic [4:0] modeCtl;
    int errors = 0;
    int samplesChecked = 0;
    always #2 sys_clk = ~sys_clk;
    station_address_mode_regs dut (.sys_clk, .arst_n, .hostReq, .rdData, .initLoad, .activityBusy,
        .twistedPairSel, .destIsBroadcast, .destIsOwn, .destHashHit, .extAddrAccept, .frameCheck,
        .addrShiftStart, .frameAccept, .addrBit, .addrBitValid, .multicastHashFilter,
        .stationAddress, .modeCtl, .linkMonitorOn, .polarityFixOn, .stopped, .suspended);
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        hostReq <= {a, d, 2'b10};
        @(posedge sys_clk);
        hostReq.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        hostReq <= {a, 16'h0000, 2'b01};
        @(posedge sys_clk);
        hostReq.rd <= 1'b0;
        #1;
        check(64'(rdData), 64'(exp));
    endtask : rd
    task automatic frame(input logic [3:0] f, input logic exp);
        @(posedge sys_clk);
        {destIsBroadcast, destIsOwn, destHashHit, extAddrAccept} <= f;
        frameCheck <= 1'b1;
        @(posedge sys_clk);
        frameCheck <= 1'b0;
        #1;
        check(64'(frameAccept), 64'(exp));
    endtask : frame
    task automatic conclude();
        if (errors == 0 && samplesChecked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    initial
    begin
        // The whole sequence needs under two hundred cycles, so this limit only trips on a hang.
        #20000;
        errors++;
        conclude();
    end
    initial
    begin
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(IDX_MODE, MODE_RESET);
        rd(IDX_CONTROL, CTL_RESET);
        for (int i = 0; i < 7; i++)
            wr(IDX_FILTER0 + 4'(i), 16'h1111 * 16'(i + 1));
        for (int i = 0; i < 7; i++)
            rd(IDX_FILTER0 + 4'(i), 16'h1111 * 16'(i + 1));
        check(multicastHashFilter, 64'h4444_3333_2222_1111);
        check(64'(stationAddress), 64'(STA));
        @(posedge sys_clk);
        addrShiftStart <= 1'b1;
        @(posedge sys_clk);
        addrShiftStart <= 1'b0;
        for (int i = 0; i < STATION_BITS; i++)
        begin
            #1;
            check(64'({addrBitValid, addrBit}), 64'({1'b1, STA[i]}));
            @(posedge sys_clk);
        end
        #1;
        check(64'(addrBitValid), 64'h0);
        wr(IDX_MODE, 16'h8000);
        frame(4'b0000, 1'b1);
        wr(IDX_MODE, 16'h4000);
        frame(4'b1000, 1'b0);
        frame(4'b0100, 1'b1);
        wr(IDX_MODE, 16'h2000);
        frame(4'b0100, 1'b0);
        frame(4'b0101, 1'b1);
        frame(4'b0010, 1'b1);
        @(posedge sys_clk);
        initLoad <= {16'h000F, 16'h1800, 1'b1};
        @(posedge sys_clk);
        initLoad.wr <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check(64'({modeCtl, linkMonitorOn, polarityFixOn}), 64'h0C);
        wr(IDX_MODE, 16'h0000);
        repeat (2) @(posedge sys_clk);
        #1;
        check(64'({linkMonitorOn, polarityFixOn}), 64'h3);
        @(posedge sys_clk);
        twistedPairSel <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check(64'({linkMonitorOn, polarityFixOn}), 64'h0);
        wr(IDX_CONTROL, 16'h0000);
        wr(IDX_MODE, 16'h8000);
        rd(IDX_MODE, READ_ZERO);
        @(posedge sys_clk);
        activityBusy <= 1'b1;
        wr(IDX_CONTROL, 16'h0002);
        repeat (4) @(posedge sys_clk);
        #1;
        check(64'(suspended), 64'h0);
        @(posedge sys_clk);
        activityBusy <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        check(64'(suspended), 64'h1);
        rd(IDX_MODE, 16'h0000);
        wr(IDX_MODE, 16'h4000);
        rd(IDX_MODE, 16'h4000);
        rd(IDX_CONTROL, 16'h0002);
        wr(IDX_CONTROL, 16'h0001);
        rd(IDX_CONTROL, 16'h0001);
        check(64'({stopped, suspended}), 64'h2);
        rd(4'h3, READ_ZERO);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(IDX_MODE, MODE_RESET);
        check(64'(modeCtl), 64'h0);
        conclude();
    end
endmodule : station_address_mode_regs_test
`default_nettype wire

//--- src/addr_mode_pkg.sv
// Package with register indices, field positions and types of the address and mode bank.
package addr_mode_pkg;
    localparam int REG_W = 16;
    localparam int ADDR_W = 4;
    // Register indices on the host port.
    localparam logic [3:0] IDX_FILTER0 = 4'h8;
    localparam logic [3:0] IDX_FILTER1 = 4'h9;
    localparam logic [3:0] IDX_FILTER2 = 4'hA;
    localparam logic [3:0] IDX_FILTER3 = 4'hB;
    localparam logic [3:0] IDX_STATION0 = 4'hC;
    localparam logic [3:0] IDX_STATION1 = 4'hD;
    localparam logic [3:0] IDX_STATION2 = 4'hE;
    localparam logic [3:0] IDX_MODE = 4'hF;
    localparam logic [3:0] IDX_CONTROL = 4'h0;
    // Mode register field positions.
    localparam int MODE_ACCEPT_ALL = 15;
    localparam int MODE_BCAST_REJECT = 14;
    localparam int MODE_OWN_MATCH_OFF = 13;
    localparam int MODE_LINK_MON_OFF = 12;
    localparam int MODE_POLARITY_OFF = 11;
    // Control register field positions.
    localparam int CTL_STOP = 0;
    localparam int CTL_SUSPEND = 1;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] CTL_RESET = 16'h0001;
    localparam logic [15:0] READ_ZERO = 16'h0000;
    localparam int STATION_BITS = 48;
    localparam logic [5:0] STATION_LAST = 6'h2F;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0] data;
        logic wr;
        logic rd;
    } host_req_s;

    typedef struct packed {
        logic [REG_W-1:0] addr;
        logic [REG_W-1:0] data;
        logic wr;
    } init_load_s;

    typedef struct packed {
        logic acceptAllFrames;
        logic broadcastReject;
        logic ownAddressMatchOff;
        logic linkPulseMonitorOff;
        logic polarityFixOff;
    } mode_ctl_s;
endpackage : addr_mode_pkg

//--- src/station_address_mode_regs.sv
// Receive address filter, station address and mode register bank.
// Operation
// RL1 - Keep 64-bit multicast hash filter as four 16-bit words, one slice each.
// RL2 - Filter and station address words hold no reset value until loaded.
// RL3 - Host register access permitted only while stop or suspend is set; the control word stays accessible at all times.
// RL4 - Station address shifts out bit 0 first, bit 47 last.
// RL5 - Mode loads from initialization block and also accepts host writes.
// RL6 - Reset clears every mode register bit.
// RL7 - Mode bit 15 accepts every frame regardless of destination.
// RL8 - Mode bit 14 rejects broadcast frames; reset clears it.
// RL9 - Mode bit 13 disables own address match; external detect may still accept.
// RL10 - Mode bit 12 set stops link pulse monitoring, twisted pair only.
// RL11 - Mode bit 11 set disables polarity correction, twisted pair only.
// RL12 - Host writes while neither stop nor suspend is set are ignored; control word writes still take effect.
// RL13 - Suspend request finishes activity, then reads back as one.
`timescale 1ns/10ps
`default_nettype none
module station_address_mode_regs
    import addr_mode_pkg::*;
#(
    parameter int FILTER_WORDS = 4,
    parameter int STATION_WORDS = 3
)
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire host_req_s hostReq,
    output logic [REG_W-1:0] rdData,
    input wire init_load_s initLoad,
    input wire logic activityBusy,
    input wire logic twistedPairSel,
    input wire logic destIsBroadcast,
    input wire logic destIsOwn,
    input wire logic destHashHit,
    input wire logic extAddrAccept,
    input wire logic frameCheck,
    input wire logic addrShiftStart,
    output logic frameAccept,
    output logic addrBit,
    output logic addrBitValid,
    output logic [63:0] multicastHashFilter,
    output logic [STATION_BITS-1:0] stationAddress,
    output logic [4:0] modeCtl,
    output logic linkMonitorOn,
    output logic polarityFixOn,
    output logic stopped,
    output logic suspended
);
    logic [REG_W-1:0] filterWord_ff [FILTER_WORDS];
    logic [REG_W-1:0] stationWord_ff [STATION_WORDS];
    logic [REG_W-1:0] mode_ff;
    logic stop_ff;
    logic suspendReq_ff;
    logic suspended_ff;
    logic [REG_W-1:0] rdData_ff;
    logic accept_ff;
    logic [5:0] shiftIdx_ff;
    logic shifting_ff;
    logic addrBit_ff;
    logic accessOk;
    logic hostWr;
    logic hostRd;
    logic hostCtlWr;
    logic [STATION_BITS-1:0] stationFlat;
    logic [63:0] filterFlat;
    mode_ctl_s modeFields;

    // Writes to the bank need stop or a completed suspend. [RL3]
    assign accessOk = stop_ff | suspended_ff;
    assign hostWr = hostReq.wr & accessOk; // [RL12]
    assign hostRd = hostReq.rd;
    assign hostCtlWr = hostReq.wr && hostReq.addr == IDX_CONTROL;
    assign stationFlat = {stationWord_ff[2], stationWord_ff[1], stationWord_ff[0]};
    assign filterFlat = {filterWord_ff[3], filterWord_ff[2], filterWord_ff[1], filterWord_ff[0]};
    assign modeFields = '{
        acceptAllFrames: mode_ff[MODE_ACCEPT_ALL],
        broadcastReject: mode_ff[MODE_BCAST_REJECT],
        ownAddressMatchOff: mode_ff[MODE_OWN_MATCH_OFF],
        linkPulseMonitorOff: mode_ff[MODE_LINK_MON_OFF],
        polarityFixOff: mode_ff[MODE_POLARITY_OFF]
    };

    // The flat ports have fixed widths, so other word counts cannot fill them.
    if (FILTER_WORDS * REG_W != $bits(multicastHashFilter)
        || STATION_WORDS * REG_W != STATION_BITS)
    begin : g_size_check
        $error("word counts do not match the filter and station port widths");
    end

    // No reset on these words: they are undefined until loaded. [RL2]
    always_ff @(posedge sys_clk)
    begin
        for (int i = 0; i < FILTER_WORDS; i++)
        begin
            if (initLoad.wr && initLoad.addr[ADDR_W-1:0] == IDX_FILTER0 + 4'(i))
            begin
                filterWord_ff[i] <= initLoad.data; // [RL1] [RL2]
            end
            else if (hostWr && hostReq.addr == IDX_FILTER0 + 4'(i))
            begin
                filterWord_ff[i] <= hostReq.data; // [RL1] [RL2]
            end
        end
    end

    // Station words follow the same load rules and have no reset either. [RL2]
    always_ff @(posedge sys_clk)
    begin
        for (int i = 0; i < STATION_WORDS; i++)
        begin
            if (initLoad.wr && initLoad.addr[ADDR_W-1:0] == IDX_STATION0 + 4'(i))
            begin
                stationWord_ff[i] <= initLoad.data; // [RL2]
            end
            else if (hostWr && hostReq.addr == IDX_STATION0 + 4'(i))
            begin
                stationWord_ff[i] <= hostReq.data; // [RL2]
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_ff <= MODE_RESET; // [RL6]
        end
        else if (initLoad.wr && initLoad.addr[ADDR_W-1:0] == IDX_MODE)
        begin
            mode_ff <= initLoad.data; // [RL5]
        end
        else if (hostWr && hostReq.addr == IDX_MODE)
        begin
            mode_ff <= hostReq.data; // [RL5]
        end
    end

    // The control word sits outside the access window, or the bank could never be reopened.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stop_ff <= CTL_RESET[CTL_STOP];
        end
        else if (hostCtlWr)
        begin
            stop_ff <= hostReq.data[CTL_STOP];
        end
    end

    // Stop forces suspend away; suspend can only be requested while running.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            suspendReq_ff <= CTL_RESET[CTL_SUSPEND];
        end
        else if (hostCtlWr)
        begin
            suspendReq_ff <= hostReq.data[CTL_SUSPEND] & ~hostReq.data[CTL_STOP];
        end
    end

    // Suspend reads back as one only once ongoing activity has drained. [RL13]
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            suspended_ff <= 1'b0;
        end
        else
        begin
            suspended_ff <= suspendReq_ff & ~stop_ff & (suspended_ff | ~activityBusy); // [RL13]
        end
    end

    // Reads other than the control word also follow the access window; outside it they return zero. [RL3]
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdData_ff <= READ_ZERO;
        end
        else if (hostRd)
        begin
            rdData_ff <= READ_ZERO;
            if (hostReq.addr == IDX_CONTROL)
            begin
                rdData_ff[CTL_STOP] <= stop_ff;
                rdData_ff[CTL_SUSPEND] <= suspended_ff; // [RL13]
            end
            else if (accessOk)
            begin
                unique case (hostReq.addr)
                    IDX_FILTER0: rdData_ff <= filterWord_ff[0];
                    IDX_FILTER1: rdData_ff <= filterWord_ff[1];
                    IDX_FILTER2: rdData_ff <= filterWord_ff[2];
                    IDX_FILTER3: rdData_ff <= filterWord_ff[3];
                    IDX_STATION0: rdData_ff <= stationWord_ff[0];
                    IDX_STATION1: rdData_ff <= stationWord_ff[1];
                    IDX_STATION2: rdData_ff <= stationWord_ff[2];
                    IDX_MODE: rdData_ff <= mode_ff;
                    default: rdData_ff <= READ_ZERO;
                endcase
            end
        end
    end

    // Accept decision for a frame whose destination checks are presented.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            accept_ff <= 1'b0;
        end
        else if (frameCheck)
        begin
            accept_ff <= modeFields.acceptAllFrames // [RL7]
                | (destIsBroadcast & ~modeFields.broadcastReject) // [RL8]
                | (destIsOwn & ~modeFields.ownAddressMatchOff) // [RL9]
                | destHashHit
                | extAddrAccept; // [RL9]
        end
        else
        begin
            accept_ff <= 1'b0;
        end
    end

    // Serial station address, lowest bit first. [RL4]
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            shiftIdx_ff <= 6'h00;
            shifting_ff <= 1'b0;
            addrBit_ff <= 1'b0;
        end
        else if (addrShiftStart && !shifting_ff)
        begin
            shiftIdx_ff <= 6'h01;
            shifting_ff <= 1'b1;
            addrBit_ff <= stationFlat[0]; // [RL4]
        end
        else if (shifting_ff)
        begin
            if (shiftIdx_ff > STATION_LAST)
            begin
                shifting_ff <= 1'b0;
            end
            else
            begin
                addrBit_ff <= stationFlat[shiftIdx_ff]; // [RL4]
                shiftIdx_ff <= shiftIdx_ff + 6'h01;
            end
        end
    end

    logic [63:0] filterOut_ff;
    logic [STATION_BITS-1:0] stationOut_ff;
    logic [4:0] modeOut_ff;
    logic linkOn_ff;
    logic polOn_ff;
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            filterOut_ff <= '0;
            stationOut_ff <= '0;
            modeOut_ff <= '0;
        end
        else
        begin
            filterOut_ff <= filterFlat;
            stationOut_ff <= stationFlat;
            modeOut_ff <= modeFields;
        end
    end

    // The enables only mean something on the twisted-pair port, so they stay off elsewhere.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            linkOn_ff <= 1'b0;
            polOn_ff <= 1'b0;
        end
        else
        begin
            linkOn_ff <= twistedPairSel & ~modeFields.linkPulseMonitorOff; // [RL10]
            polOn_ff <= twistedPairSel & ~modeFields.polarityFixOff; // [RL11]
        end
    end

    assign rdData = rdData_ff;
    assign frameAccept = accept_ff;
    assign addrBit = addrBit_ff;
    // The shift flag is high for exactly the cycles in which an address bit stands. [RL4]
    assign addrBitValid = shifting_ff;
    assign multicastHashFilter = filterOut_ff;
    assign stationAddress = stationOut_ff;
    assign modeCtl = modeOut_ff;
    assign linkMonitorOn = linkOn_ff;
    assign polarityFixOn = polOn_ff;
    assign stopped = stop_ff;
    assign suspended = suspended_ff;
endmodule : station_address_mode_regs
`default_nettype wire
